// ### rtl/pfw_map.vh
// Pin timing counts and address layout for the flash host controller
`ifndef PFW_MAP_VH
`define PFW_MAP_VH
`define PFW_ADDR_W 19
`define PFW_DATA_W 16
`define PFW_CLK_MHZ 100
`define PFW_PROG_MAX_US 40
`define PFW_PROG_MAX_CYC (`PFW_PROG_MAX_US * `PFW_CLK_MHZ)
`define PFW_STROBE_NS 80
`define PFW_STROBE_CYC ((`PFW_STROBE_NS * `PFW_CLK_MHZ + 999) / 1000)
`define PFW_SETUP_CYC 2
`define PFW_UNLOCK_A1 19'h05555
`define PFW_UNLOCK_D1 16'h00aa
`define PFW_UNLOCK_A2 19'h02aaa
`define PFW_UNLOCK_D2 16'h0055
`define PFW_UNLOCK_A3 19'h05555
`define PFW_UNLOCK_D3 16'h00a0
`define PFW_POLL_BIT 7
`define PFW_TOGGLE_BIT 6
`define PFW_SECTOR_LSB 11
`define PFW_BLOCK_LSB 15
`endif

// ### rtl/pfw_strobe.v
// One bus cycle on the flash pins: write or read, fixed-length strobe
`timescale 1ns/1ns
`include "pfw_map.vh"
module pfw_strobe #(
  parameter STROBE_CYC = `PFW_STROBE_CYC,
  parameter SETUP_CYC = `PFW_SETUP_CYC
)(
  // Clock and reset
  input wire mclk,
  input wire srst,
  // Request
  input wire start,
  input wire is_write,
  // Phase outputs
  output reg select_n_reg,
  output reg gate_n_reg,
  output reg wstrobe_n_reg,
  output reg drive_reg,
  output reg sample,
  output reg done
);
  localparam S_IDLE = 2'd0;
  localparam S_SETUP = 2'd1;
  localparam S_STROBE = 2'd2;
  localparam S_HOLD = 2'd3;
  reg [1:0] state_reg;
  reg [7:0] cnt_reg;
  reg wr_reg;
  always @(posedge mclk)
  begin
    if (srst)
    begin
      state_reg <= S_IDLE;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
      select_n_reg <= 1'b1;
      gate_n_reg <= 1'b1;
      wstrobe_n_reg <= 1'b1;
      drive_reg <= 1'b0;
      sample <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      sample <= 1'b0;
      done <= 1'b0;
      case (state_reg)
        S_IDLE:
          if (start)
          begin
            // Chip select goes low first so write strobe falls later
            wr_reg <= is_write;
            select_n_reg <= 1'b0;
            drive_reg <= is_write;
            cnt_reg <= SETUP_CYC[7:0];
            state_reg <= S_SETUP;
          end
        S_SETUP:
          if (cnt_reg <= 8'h01)
          begin
            wstrobe_n_reg <= ~wr_reg; // RL2
            gate_n_reg <= wr_reg; // RL5
            cnt_reg <= STROBE_CYC[7:0];
            state_reg <= S_STROBE;
          end
          else
            cnt_reg <= cnt_reg - 8'h01;
        S_STROBE:
          if (cnt_reg <= 8'h01)
          begin
            // Write strobe rises before chip select, so data is held valid
            wstrobe_n_reg <= 1'b1;
            gate_n_reg <= 1'b1;
            sample <= ~wr_reg;
            state_reg <= S_HOLD;
          end
          else
            cnt_reg <= cnt_reg - 8'h01;
        S_HOLD:
        begin
          select_n_reg <= 1'b1; // RL7
          drive_reg <= 1'b0;
          done <= 1'b1;
          state_reg <= S_IDLE;
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

// ### rtl/pfw_host.v
// Host controller for a 16-bit parallel NOR flash: read and word program
//
// Behaviour
// RL1 - Device holds 512K words of 16 bits, 19 address lines, 16 data lines.
// RL2 - Host writes by pulling write strobe low while chip select is low.
// RL3 - Device latches address at the later falling edge of strobe or select.
// RL4 - Device latches data at the earlier rising edge of strobe or select.
// RL5 - Read data appears only with chip select and output gate both low.
// RL6 - Device floats data lines when chip select or output gate is high.
// RL7 - Chip select high deselects the device into standby.
// RL8 - One program changes exactly one word at the final write's address.
// RL9 - Host programs a word only in a sector erased since last program; this host has no erase and programs any word on request.
// RL10 - Program is three unlock writes then address and data write.
// RL11 - Internal program starts after the earlier rising edge of the fourth write.
// RL12 - Internal program ends within 40 us; host may time out on it.
// RL13 - During program reads give only status bits, not array data.
// RL14 - Device ignores commands written during an internal program.
// RL15 - Sector erase selects sector by address bits 18 to 11.
// RL16 - Block erase selects block by address bits 18 to 15.
// RL17 - During program bit 7 reads inverted; true after completion.
// RL18 - During program bit 6 flips on each read; stops when done.
// RL19 - Invalid write in unlock sequence returns device to read mode.
// RL20 - After program completes, reads return array contents again.
`timescale 1ns/1ns
`include "pfw_map.vh"
module pfw_host #(
  parameter ADDR_W = `PFW_ADDR_W,
  parameter DATA_W = `PFW_DATA_W,
  parameter PROG_MAX_CYC = `PFW_PROG_MAX_CYC
)(
  // Clock and reset
  input wire mclk,
  input wire srst,
  // User command port
  input wire cmd_valid,
  input wire cmd_write,
  input wire [ADDR_W-1:0] cmd_addr,
  input wire [DATA_W-1:0] cmd_wdata,
  output reg cmd_ready,
  output reg rsp_valid,
  output reg [DATA_W-1:0] rsp_rdata,
  output reg rsp_timeout,
  // Flash pins
  output reg [ADDR_W-1:0] address_lines,
  output reg [DATA_W-1:0] data_lines_out,
  output reg data_lines_oe,
  input wire [DATA_W-1:0] data_lines_in,
  output reg flash_select_n,
  output reg flash_gate_n,
  output reg flash_wstrobe_n
);
  localparam S_IDLE = 3'd0;
  localparam S_UNLOCK = 3'd1;
  localparam S_PROG = 3'd2;
  localparam S_POLL = 3'd3;
  localparam S_READ = 3'd4;
  localparam S_DONE = 3'd5;
  localparam CNT_W = 24;

  reg [2:0] state_reg;
  reg [1:0] step_reg;
  reg [ADDR_W-1:0] addr_reg;
  reg [DATA_W-1:0] wdata_reg;
  reg [CNT_W-1:0] tmo_reg;
  reg busy_reg;
  reg start_reg;
  reg is_wr_reg;
  reg [DATA_W-1:0] sync1_reg;
  reg [DATA_W-1:0] sync2_reg;
  reg [1:0] smp_dly_reg;
  wire st_sel_n;
  wire st_gate_n;
  wire st_wstb_n;
  wire st_drive;
  wire st_sample;
  wire st_done;
  wire [DATA_W-1:0] rd;
  wire poll_match;

  pfw_strobe u_strobe (
    .mclk(mclk),
    .srst(srst),
    .start(start_reg),
    .is_write(is_wr_reg),
    .select_n_reg(st_sel_n),
    .gate_n_reg(st_gate_n),
    .wstrobe_n_reg(st_wstb_n),
    .drive_reg(st_drive),
    .sample(st_sample),
    .done(st_done)
  );

  // Pins copied into top-level flops so every output leaves a register
  always @(posedge mclk)
  begin
    if (srst)
    begin
      flash_select_n <= 1'b1;
      flash_gate_n <= 1'b1;
      flash_wstrobe_n <= 1'b1;
      data_lines_oe <= 1'b0;
    end
    else
    begin
      flash_select_n <= st_sel_n; // RL7
      flash_gate_n <= st_gate_n;
      flash_wstrobe_n <= st_wstb_n;
      data_lines_oe <= st_drive & ~st_gate_n ? 1'b0 : st_drive; // RL6
    end
  end

  // Data pins come from outside; two flops before use
  always @(posedge mclk)
  begin
    if (srst)
    begin
      sync1_reg <= {DATA_W{1'b0}};
      sync2_reg <= {DATA_W{1'b0}};
      smp_dly_reg <= 2'b00;
    end
    else
    begin
      sync1_reg <= data_lines_in;
      sync2_reg <= sync1_reg;
      smp_dly_reg <= {smp_dly_reg[0], st_sample};
    end
  end
  // Sample taken while gate still low; two-flop delay lines it up
  assign rd = sync2_reg;
  assign poll_match = (rd[`PFW_POLL_BIT] == wdata_reg[`PFW_POLL_BIT]); // RL17

  always @(posedge mclk)
  begin
    if (srst)
    begin
      state_reg <= S_IDLE;
      step_reg <= 2'd0;
      addr_reg <= {ADDR_W{1'b0}};
      wdata_reg <= {DATA_W{1'b0}};
      tmo_reg <= {CNT_W{1'b0}};
      busy_reg <= 1'b0;
      start_reg <= 1'b0;
      is_wr_reg <= 1'b0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= {DATA_W{1'b0}};
      rsp_timeout <= 1'b0;
      address_lines <= {ADDR_W{1'b0}};
      data_lines_out <= {DATA_W{1'b0}};
    end
    else
    begin
      start_reg <= 1'b0;
      rsp_valid <= 1'b0;
      cmd_ready <= (state_reg == S_IDLE) & ~cmd_valid & ~busy_reg;
      if (busy_reg && tmo_reg != {CNT_W{1'b0}})
        tmo_reg <= tmo_reg - {{(CNT_W-1){1'b0}}, 1'b1}; // RL12
      case (state_reg)
        S_IDLE:
          if (cmd_valid && cmd_ready)
          begin
            cmd_ready <= 1'b0;
            addr_reg <= cmd_addr;
            wdata_reg <= cmd_wdata;
            rsp_timeout <= 1'b0;
            start_reg <= 1'b1;
            if (cmd_write)
            begin
              // Unlock first; a broken sequence aborts in the device
              step_reg <= 2'd0;
              is_wr_reg <= 1'b1;
              address_lines <= `PFW_UNLOCK_A1; // RL10
              data_lines_out <= `PFW_UNLOCK_D1;
              state_reg <= S_UNLOCK;
            end
            else
            begin
              is_wr_reg <= 1'b0;
              address_lines <= cmd_addr; // RL1
              state_reg <= S_READ;
            end
          end
        S_UNLOCK:
          if (st_done)
          begin
            start_reg <= 1'b1;
            step_reg <= step_reg + 2'd1;
            case (step_reg)
              2'd0:
              begin
                address_lines <= `PFW_UNLOCK_A2;
                data_lines_out <= `PFW_UNLOCK_D2;
              end
              2'd1:
              begin
                address_lines <= `PFW_UNLOCK_A3;
                data_lines_out <= `PFW_UNLOCK_D3;
              end
              default:
              begin
                address_lines <= addr_reg; // RL8
                data_lines_out <= wdata_reg;
                state_reg <= S_PROG;
              end
            endcase
          end
        S_PROG:
          if (st_done)
          begin
            // Internal program now running; only status polls follow
            busy_reg <= 1'b1; // RL11
            tmo_reg <= PROG_MAX_CYC[CNT_W-1:0];
            is_wr_reg <= 1'b0;
            start_reg <= 1'b1;
            state_reg <= S_POLL;
          end
        S_POLL:
          if (smp_dly_reg[1])
          begin
            if (poll_match) // RL13
            begin
              busy_reg <= 1'b0; // RL20
              state_reg <= S_DONE;
            end
            else if (tmo_reg == {CNT_W{1'b0}})
            begin
              busy_reg <= 1'b0;
              rsp_timeout <= 1'b1;
              state_reg <= S_DONE;
            end
            else
              start_reg <= 1'b1; // RL14
          end
        S_READ:
          if (smp_dly_reg[1])
          begin
            rsp_rdata <= rd; // RL5
            rsp_valid <= 1'b1;
            state_reg <= S_IDLE;
          end
        S_DONE:
        begin
          rsp_rdata <= wdata_reg;
          rsp_valid <= 1'b1;
          state_reg <= S_IDLE;
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

// ### bench/pfw_host_checker.sv
// Pin-level assertions for the flash host controller
`timescale 1ns/1ns
`include "pfw_map.vh"
module pfw_host_checker #(
  parameter PROG_MAX_CYC = 4000
)(
  input wire mclk,
  input wire srst,
  input wire cmd_valid,
  input wire cmd_write,
  input wire cmd_ready,
  input wire [18:0] cmd_addr,
  input wire [15:0] cmd_wdata,
  input wire rsp_valid,
  input wire rsp_timeout,
  input wire [18:0] address_lines,
  input wire [15:0] data_lines_out,
  input wire data_lines_oe,
  input wire flash_select_n,
  input wire flash_gate_n,
  input wire flash_wstrobe_n
);
  reg [18:0] a_reg;
  reg [15:0] d_reg;
  reg m_reg;
  reg [2:0] n_reg;
  reg [15:0] t_reg;
  reg [34:0] exp_w;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // Write count since take; 5 marks the answer so the wait counter freezes
  always @(posedge mclk)
    if (srst || (cmd_valid && cmd_ready))
    begin
      a_reg <= cmd_addr;
      d_reg <= cmd_wdata;
      m_reg <= cmd_write;
      n_reg <= 3'h0;
      t_reg <= 16'h0000;
    end
    else
    begin
      if ($rose(flash_wstrobe_n))
        n_reg <= n_reg + 3'h1;
      if (rsp_valid)
        n_reg <= 3'h5;
      if (n_reg == 3'h4)
        t_reg <= t_reg + 16'h0001;
    end
  always @*
    case (n_reg)
      3'h0: exp_w = {`PFW_UNLOCK_A1, `PFW_UNLOCK_D1};
      3'h1: exp_w = {`PFW_UNLOCK_A2, `PFW_UNLOCK_D2};
      3'h2: exp_w = {`PFW_UNLOCK_A3, `PFW_UNLOCK_D3};
      default: exp_w = {a_reg, d_reg};
    endcase
  a_write_selected: assert property (!flash_wstrobe_n |-> !flash_select_n)
    else $error("write strobe outside select");
  a_read_gated: assert property (!flash_gate_n |->
    !flash_select_n && !data_lines_oe && flash_wstrobe_n)
    else $error("bad read gating");
  a_write_held: assert property (!flash_wstrobe_n ##1 !flash_wstrobe_n |->
    $stable(address_lines) && $stable(data_lines_out) && data_lines_oe)
    else $error("write not held");
  a_write_order: assert property ($fell(flash_wstrobe_n) |-> n_reg < 3'h4
    && {address_lines, data_lines_out} == exp_w)
    else $error("wrong write in sequence");
  a_strobe_width: assert property ($fell(flash_wstrobe_n) |-> (!flash_wstrobe_n)[*8])
    else $error("write strobe too short");
  a_poll_bound: assert property (t_reg <= PROG_MAX_CYC + 64)
    else $error("poll never ends");
  a_timeout_late: assert property (rsp_valid && rsp_timeout |-> t_reg + 4 >= PROG_MAX_CYC)
    else $error("early timeout");
  a_answer_writes: assert property (rsp_valid |-> n_reg == (m_reg ? 3'h4 : 3'h0))
    else $error("write count at answer");
  a_idle_standby: assert property (cmd_ready |-> flash_select_n && !data_lines_oe)
    else $error("pins busy while idle");
  c_read: cover property (rsp_valid && !m_reg);
  c_prog: cover property (rsp_valid && m_reg && !rsp_timeout);
  c_tout: cover property (rsp_valid && rsp_timeout);
endmodule
bind pfw_host pfw_host_checker #(.PROG_MAX_CYC(PROG_MAX_CYC)) pfw_host_checker_i (.mclk,
  .srst, .cmd_valid, .cmd_write, .cmd_ready, .cmd_addr, .cmd_wdata, .rsp_valid,
  .rsp_timeout, .address_lines, .data_lines_out, .data_lines_oe, .flash_select_n,
  .flash_gate_n, .flash_wstrobe_n);

// ### bench/pfw_flash_model.sv
// Behavioural flash device: word array, unlock, program and status reads
`timescale 1ns/1ns
`include "pfw_map.vh"
module pfw_flash_model #(
  parameter ACC_NS = 20
)(
  // Pins
  input wire [18:0] address_lines,
  input wire [15:0] data_lines,
  output wire [15:0] dev_data,
  output wire dev_oe,
  input wire flash_select_n,
  input wire flash_gate_n,
  input wire flash_wstrobe_n,
  // Internal program time
  input wire [31:0] prog_ns
);
  localparam logic [34:0] UC [0:2] = '{{`PFW_UNLOCK_A1, `PFW_UNLOCK_D1},
    {`PFW_UNLOCK_A2, `PFW_UNLOCK_D2}, {`PFW_UNLOCK_A3, `PFW_UNLOCK_D3}};
  logic [15:0] mem [int];
  logic [18:0] lat_a;
  logic [18:0] pa;
  logic [15:0] pd;
  logic [15:0] q;
  int step = 0;
  bit busy = 0;
  bit tog = 0;
  wire wr = !flash_select_n && !flash_wstrobe_n;
  always @(posedge wr) lat_a = address_lines;
  always @(negedge wr)
    if (!busy)
    begin
      if (step == 3)
      begin
        pa = lat_a;
        pd = data_lines & (mem.exists(pa) ? mem[pa] : 16'hffff);
        busy = 1;
        step = 0;
        fork
          #(prog_ns)
          begin
            mem[pa] = pd;
            busy = 0;
          end
        join_none
      end
      else if ({lat_a, data_lines} == UC[step])
        step++;
      else
        step = 0;
    end
  always @(posedge flash_gate_n) if (busy && !flash_select_n) tog = ~tog;
  // Status only while busy; array contents never leak out
  always @(address_lines or busy or tog)
    q = busy ? {8'h00, ~pd[7], tog, 6'h00} :
      mem.exists(address_lines) ? mem[address_lines] : 16'hffff;
  assign #(ACC_NS) dev_oe = !flash_select_n && !flash_gate_n;
  assign #(ACC_NS) dev_data = q;
endmodule

// ### bench/pfw_host_tb.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ns
module pfw_host_tb;
  localparam PMAX = 300;
  logic mclk = 0;
  logic srst = 1;
  logic cmd_valid = 0;
  logic cmd_write = 0;
  logic [18:0] cmd_addr = 0;
  logic [15:0] cmd_wdata = 0;
  logic [31:0] prog_ns = 500;
  wire cmd_ready, rsp_valid, rsp_timeout, data_lines_oe, dev_oe;
  wire flash_select_n, flash_gate_n, flash_wstrobe_n;
  wire [15:0] rsp_rdata, data_lines_out, dev_data, data_lines;
  wire [18:0] address_lines;
  logic [15:0] last_d = 0;
  logic [15:0] got;
  logic [15:0] ref_mem [int];
  logic tout, g6;
  logic [18:0] a;
  logic [15:0] d;
  int fail_count = 0;
  int checks = 0;
  // Released bus shows the inverse of the last driven value
  assign data_lines = data_lines_oe ? data_lines_out : dev_oe ? dev_data : ~last_d;
  always @* if (data_lines_oe || dev_oe) last_d = data_lines_oe ? data_lines_out : dev_data;
  pfw_host #(.PROG_MAX_CYC(PMAX)) pfw_host_i (.mclk, .srst, .cmd_valid, .cmd_write,
    .cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_rdata, .rsp_timeout, .address_lines,
    .data_lines_out, .data_lines_oe, .data_lines_in(data_lines), .flash_select_n,
    .flash_gate_n, .flash_wstrobe_n);
  pfw_flash_model pfw_flash_model_i (.address_lines, .data_lines, .dev_data, .dev_oe,
    .flash_select_n, .flash_gate_n, .flash_wstrobe_n, .prog_ns);
  initial forever #5 mclk = ~mclk;
  function automatic logic [15:0] refv(input logic [18:0] x);
    return ref_mem.exists(x) ? ref_mem[x] : 16'hffff;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic op(input logic w, input logic [18:0] x, input logic [15:0] v);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 100)
      chk(16'h0000, 16'h0001, "never ready");
    cmd_valid = 1;
    cmd_write = w;
    cmd_addr = x;
    cmd_wdata = v;
    @(posedge mclk);
    #1;
    cmd_valid = 0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 2000)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 2000)
      chk(16'h0000, 16'h0001, "no response");
    got = rsp_rdata;
    tout = rsp_timeout;
  endtask
  task automatic rd(input logic [18:0] x);
    op(1'b0, x, 16'h0000);
    chk(got, refv(x), "read");
  endtask
  task automatic prog(input logic [18:0] x, input logic [15:0] v);
    op(1'b1, x, v);
    ref_mem[x] = v & refv(x);
    chk(got, ref_mem[x], "program");
    chk({15'h0, tout}, 16'h0000, "program timeout flag");
  endtask
  task report_and_stop;
    $display("TB: %0d checks, %0d mismatches", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    void'($urandom(36272));
    repeat (3) @(posedge mclk);
    #1;
    srst = 0;
    chk({flash_select_n, flash_wstrobe_n, data_lines_oe}, 16'h0006, "idle pins");
    $display("TB: reset test done");
    for (int i = 0; i < 8; i++)
    begin
      a = i == 0 ? 19'h00000 : i == 1 ? 19'h7ffff : 19'($urandom);
      d = i == 2 ? 16'h0080 : i == 3 ? 16'h0000 : 16'($urandom);
      rd(a);
      prog(a, d);
      rd(a);
      rd(a ^ 19'h00001);
    end
    $display("TB: program test done");
    prog_ns = PMAX * 40;
    a = 19'($urandom);
    d = 16'($urandom);
    op(1'b1, a, d);
    chk({15'h0, tout}, 16'h0001, "timeout");
    ref_mem[a] = d & refv(a);
    op(1'b0, a, 16'h0000);
    chk({got[7], tout}, {~d[7], 1'b0}, "poll bit");
    g6 = got[6];
    op(1'b0, a, 16'h0000);
    chk({15'h0, got[6]}, {15'h0, ~g6}, "toggle bit");
    op(1'b1, a ^ 19'h00002, ~d);
    #(prog_ns);
    rd(a);
    rd(a ^ 19'h00002);
    $display("TB: slow program test done");
    report_and_stop;
  end
  initial
  begin
    #400000;
    fail_count++;
    report_and_stop;
  end
endmodule
